// ### rtl/phy_link_pkg.sv
// Constants, types and helpers for the PHY link management block.
package phy_link_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int HALT_MS = 1200;
   localparam int LOSS_MS = 50;
   localparam int GAP_MS = 16;
   localparam int JAB_MS = 20;
   localparam int HALT_CYC = HALT_MS * (CLK_HZ / 1000);
   localparam int LOSS_CYC = LOSS_MS * (CLK_HZ / 1000);
   localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
   localparam int JAB_CYC = JAB_MS * (CLK_HZ / 1000);
   localparam logic [1:0] POL_COUNT = 2'h3;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_MAC_CTRL = 4'h0;
   localparam logic [3:0] REG_PHY_CTRL = 4'h1;
   localparam logic [3:0] REG_CFG1 = 4'h2;
   localparam logic [3:0] REG_CFG2 = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_STS_OUT = 4'h5;
   localparam logic [3:0] REG_ADV = 4'h6;
   localparam logic [3:0] REG_PARTNER = 4'h7;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MAC_NEG_BIT = 0;
   localparam int MAC_SPD_BIT = 1;
   localparam int MAC_DPX_BIT = 2;
   localparam int PHY_DPX_BIT = 8;
   localparam int PHY_RST_BIT = 9;
   localparam int PHY_NEG_BIT = 12;
   localparam int PHY_SPD_BIT = 13;
   localparam int CFG1_LDIS_BIT = 0;
   localparam int CFG2_JDIS_BIT = 0;
   localparam int CFG2_PDIS_BIT = 1;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_JAB_BIT = 1;
   localparam int ST_LINK_BIT = 2;
   localparam int SO_SPD_BIT = 0;
   localparam int SO_DPX_BIT = 1;
   localparam int SO_JAB_BIT = 2;
   localparam int SO_POL_BIT = 3;
   localparam int ACK_BIT = 14;
   localparam int ABL_100FD = 8;
   localparam int ABL_100HD = 7;
   localparam int ABL_10FD = 6;
   localparam int ABL_10HD = 5;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic RST_MAC_NEG = 1'b0;
   localparam logic RST_MAC_SPD = 1'b0;
   localparam logic RST_MAC_DPX = 1'b0;
   localparam logic RST_PHY_NEG = 1'b1;
   localparam logic RST_PHY_SPD = 1'b1;
   localparam logic RST_PHY_DPX = 1'b0;
   localparam logic [15:0] RST_ADV = 16'h01E1;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_HALT = 3'b001,
      ST_DETECT = 3'b010,
      ST_ACK = 3'b011,
      ST_LINK = 3'b100
   } neg_state_t;

   typedef struct packed {
      logic nlp;
      logic nlp_inv;
      logic start_of_idle_pulse;
      logic soi_inv;
      logic squelch_ok;
      logic descr_lock;
      logic rx_active;
      logic flp_valid;
   } line_in_t;

   typedef struct packed {
      logic ok;
      logic spd100;
      logic fdx;
   } mode_t;

   // Picks the highest common mode: 100 full, 100 half, 10 full, 10 half.
   function automatic mode_t resolve(input logic [15:0] own, input logic [15:0] peer);
      logic [15:0] both;
      mode_t m;
      both = own & peer;
      m = '{ok: 1'b1, spd100: 1'b0, fdx: 1'b0};
      if (both[ABL_100FD]) begin
         m = '{ok: 1'b1, spd100: 1'b1, fdx: 1'b1};
      end else if (both[ABL_100HD]) begin
         m = '{ok: 1'b1, spd100: 1'b1, fdx: 1'b0};
      end else if (both[ABL_10FD]) begin
         m = '{ok: 1'b1, spd100: 1'b0, fdx: 1'b1};
      end else if (!both[ABL_10HD]) begin
         m.ok = 1'b0;
      end
      return m;
   endfunction

endpackage

// ### rtl/phy_link_ctrl.sv
// Link integrity, auto-negotiation, jabber and polarity logic of the PHY.
//
// Function
// - 10M link pass from normal link pulses.
// - 100M link from squelch and descrambler lock.
// - Capabilities exchanged as sixteen-bit pulse bursts.
// - Negotiate on enable, link fail, restart.
// - Plain partner signalling selects matching speed.
// - Advertise, resolve by priority, set mode.
// - Result kept in speed and duplex bits.
// - Done flag only after successful negotiation.
// - Negotiation needs both enable bits set.
// - Enabling halts transmit, then link fail.
// - MAC enable clear: MAC select bits rule.
// - PHY enable clear, MAC enable set: PHY select bits rule.
// - Restart bit starts negotiation any time.
// - Link disable forces pass, PHY mode bits.
// - No jabber detection at 100M.
// - 10M jabber idles transmitter, collision, status.
// - Jabber disable bit skips jabber detection.
// - Reverse polarity after 3 pulses or idle.
// - Invert receive data unless autopolarity disabled.
// - Full duplex suppresses all collision indication.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
module phy_link_ctrl
   import phy_link_pkg::*;
#(
   parameter int HALT_TIME = HALT_CYC,
   parameter int LOSS_TIME = LOSS_CYC,
   parameter int GAP_TIME = GAP_CYC,
   parameter int JAB_TIME = JAB_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic tx_en,
   input wire line_in_t line_in,
   input wire logic [15:0] flp_rx_word,
   output logic tx_link_pulse,
   output logic tx_flp_send,
   output logic [15:0] tx_flp_word,
   output logic tx_idle_100,
   output logic tx_hold,
   output logic link_pass,
   output logic speed_100,
   output logic full_duplex,
   output logic collision,
   output logic rx_invert
);

   localparam logic [23:0] HALT_LIM = 24'(HALT_TIME - 1);
   localparam logic [19:0] LOSS_LIM = 20'(LOSS_TIME - 1);
   localparam logic [17:0] GAP_LIM = 18'(GAP_TIME - 1);
   localparam logic [17:0] JAB_LIM = 18'(JAB_TIME - 1);

   // ---------------------------------------------------------------
   // Input synchronisers and event detection
   // ---------------------------------------------------------------
   line_in_t sync1, sync2, prev;
   logic [15:0] word1, word2;
   logic nlp_ev, soi_ev, flp_ev;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
         word1 <= 16'h0000;
         word2 <= 16'h0000;
      end else begin
         sync1 <= line_in;
         sync2 <= sync1;
         prev <= sync2;
         word1 <= flp_rx_word;
         word2 <= word1;
      end
   end

   assign nlp_ev = sync2.nlp & ~prev.nlp;
   assign soi_ev = sync2.start_of_idle_pulse & ~prev.start_of_idle_pulse;
   assign flp_ev = sync2.flp_valid & ~prev.flp_valid;

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic mac_side_negotiate_enable, mac_spd, mac_dpx;
   logic phy_side_negotiate_enable, phy_spd, duplex_select;
   logic link_dis, jab_dis, apol_dis;
   logic [15:0] adv, partner;
   logic restart_req;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mac_side_negotiate_enable <= RST_MAC_NEG;
         mac_spd <= RST_MAC_SPD;
         mac_dpx <= RST_MAC_DPX;
         phy_side_negotiate_enable <= RST_PHY_NEG;
         phy_spd <= RST_PHY_SPD;
         duplex_select <= RST_PHY_DPX;
         link_dis <= 1'b0;
         jab_dis <= 1'b0;
         apol_dis <= 1'b0;
         adv <= RST_ADV;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_MAC_CTRL: begin
               mac_side_negotiate_enable <= reg_wdata[MAC_NEG_BIT];
               mac_spd <= reg_wdata[MAC_SPD_BIT];
               mac_dpx <= reg_wdata[MAC_DPX_BIT];
            end
            REG_PHY_CTRL: begin
               phy_side_negotiate_enable <= reg_wdata[PHY_NEG_BIT];
               phy_spd <= reg_wdata[PHY_SPD_BIT];
               duplex_select <= reg_wdata[PHY_DPX_BIT];
            end
            REG_CFG1: begin
               link_dis <= reg_wdata[CFG1_LDIS_BIT];
            end
            REG_CFG2: begin
               jab_dis <= reg_wdata[CFG2_JDIS_BIT];
               apol_dis <= reg_wdata[CFG2_PDIS_BIT];
            end
            REG_ADV: begin
               adv <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // Restart bit is self-clearing: a write of one is a single event.
   assign restart_req = reg_wr && reg_addr == REG_PHY_CTRL && reg_wdata[PHY_RST_BIT];

   // ---------------------------------------------------------------
   // Negotiation state machine
   // ---------------------------------------------------------------
   neg_state_t state;
   logic neg_on, neg_on_d, start_neg;
   logic [23:0] timer;
   logic neg_spd, neg_fdx, negotiate_done_flag;
   logic spd100, fdx, link_good;
   logic [19:0] loss_cnt;
   mode_t res;

   assign neg_on = mac_side_negotiate_enable & phy_side_negotiate_enable;
   assign start_neg = neg_on & (~neg_on_d | restart_req);
   assign res = resolve(adv, word2);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         neg_on_d <= 1'b0;
      end else begin
         neg_on_d <= neg_on;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_OFF;
         timer <= 24'h000000;
         neg_spd <= 1'b0;
         neg_fdx <= 1'b0;
         partner <= 16'h0000;
      end else if (!neg_on) begin
         state <= ST_OFF;
         timer <= 24'h000000;
      end else if (start_neg) begin
         state <= ST_HALT;
         timer <= 24'h000000;
      end else begin
         unique case (state)
            ST_OFF: begin
               state <= ST_HALT;
            end
            ST_HALT: begin
               timer <= timer + 24'h000001;
               if (timer == HALT_LIM) begin
                  state <= ST_DETECT;
               end
            end
            ST_DETECT: begin
               timer <= 24'h000000;
               if (flp_ev) begin
                  partner <= word2;
                  state <= ST_ACK;
               end else if (sync2.squelch_ok && sync2.descr_lock) begin
                  neg_spd <= 1'b1;
                  neg_fdx <= 1'b0;
                  state <= ST_LINK;
               end else if (nlp_ev) begin
                  neg_spd <= 1'b0;
                  neg_fdx <= 1'b0;
                  state <= ST_LINK;
               end
            end
            ST_ACK: begin
               timer <= timer + 24'h000001;
               if (flp_ev && word2[ACK_BIT]) begin
                  partner <= word2;
                  state <= res.ok ? ST_LINK : ST_DETECT;
                  neg_spd <= res.spd100;
                  neg_fdx <= res.fdx;
               end else if (timer[19:0] == LOSS_LIM) begin
                  state <= ST_DETECT;
               end
            end
            ST_LINK: begin
               if (!link_good) begin
                  state <= ST_DETECT;
               end
            end
            default: begin
               state <= ST_OFF;
            end
         endcase
      end
   end

   // Done flag: cleared when a negotiation starts, set on pulse exchange success.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         negotiate_done_flag <= 1'b0;
      end else if (neg_on && !start_neg && state == ST_ACK && flp_ev &&
                   word2[ACK_BIT] && res.ok) begin
         negotiate_done_flag <= 1'b1;
      end else if (!neg_on || start_neg || state == ST_DETECT) begin
         negotiate_done_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Mode selection and link check
   // ---------------------------------------------------------------
   always_comb begin
      if (link_dis || (mac_side_negotiate_enable && !phy_side_negotiate_enable)) begin
         spd100 = phy_spd;
         fdx = duplex_select;
      end else if (!mac_side_negotiate_enable) begin
         spd100 = mac_spd;
         fdx = mac_dpx;
      end else begin
         spd100 = neg_spd;
         fdx = neg_fdx;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         loss_cnt <= LOSS_LIM;
      end else if (nlp_ev || spd100 || (neg_on && state != ST_LINK)) begin
         loss_cnt <= 20'h00000;
      end else if (loss_cnt != LOSS_LIM) begin
         loss_cnt <= loss_cnt + 20'h00001;
      end
   end

   always_comb begin
      if (spd100) begin
         link_good = sync2.squelch_ok & sync2.descr_lock;
      end else begin
         link_good = loss_cnt != LOSS_LIM;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         link_pass <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
      end else begin
         link_pass <= link_dis | (link_good & (!neg_on | state == ST_LINK));
         speed_100 <= spd100;
         full_duplex <= fdx;
      end
   end

   // ---------------------------------------------------------------
   // Transmit pulses and idle
   // ---------------------------------------------------------------
   logic [17:0] gap_cnt;
   logic halted, negotiating, gap_hit;

   assign halted = neg_on && !link_dis && (state == ST_HALT || state == ST_OFF);
   assign negotiating = neg_on && !link_dis && (state == ST_DETECT || state == ST_ACK);
   assign gap_hit = gap_cnt == GAP_LIM;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gap_cnt <= 18'h00000;
         tx_link_pulse <= 1'b0;
         tx_flp_send <= 1'b0;
         tx_flp_word <= 16'h0000;
         tx_idle_100 <= 1'b0;
      end else begin
         gap_cnt <= gap_hit ? 18'h00000 : gap_cnt + 18'h00001;
         tx_link_pulse <= gap_hit && !halted && !negotiating && !spd100 && !tx_en;
         tx_flp_send <= gap_hit && negotiating;
         tx_flp_word <= adv | (state == ST_ACK ? 16'h4000 : 16'h0000);
         tx_idle_100 <= spd100 && !halted && !negotiating && !tx_en;
      end
   end

   // ---------------------------------------------------------------
   // Jabber and collision
   // ---------------------------------------------------------------
   logic [17:0] jab_cnt;
   logic jabber, jab_sts, jab_so, jab_set, rd_status, rd_so;

   assign rd_status = reg_rd && reg_addr == REG_STATUS;
   assign rd_so = reg_rd && reg_addr == REG_STS_OUT;
   assign jab_set = tx_en && jab_cnt == JAB_LIM && !spd100 && !jab_dis;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         jab_cnt <= 18'h00000;
         jabber <= 1'b0;
      end else if (spd100 || jab_dis || !tx_en) begin
         jab_cnt <= 18'h00000;
         jabber <= 1'b0;
      end else if (jab_set) begin
         jabber <= 1'b1;
      end else begin
         jab_cnt <= jab_cnt + 18'h00001;
      end
   end

   // Sticky jabber bits clear on read; a new event in the read cycle wins.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         jab_sts <= 1'b0;
         jab_so <= 1'b0;
      end else begin
         jab_sts <= jab_set | (jab_sts & ~rd_status);
         jab_so <= jab_set | (jab_so & ~rd_so);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         collision <= 1'b0;
         tx_hold <= 1'b0;
      end else begin
         collision <= !fdx && (jabber || (tx_en && sync2.rx_active && link_pass));
         tx_hold <= jabber || halted;
      end
   end

   // ---------------------------------------------------------------
   // Receive polarity
   // ---------------------------------------------------------------
   logic [1:0] pol_cnt;
   logic rev_pol;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pol_cnt <= 2'h0;
         rev_pol <= 1'b0;
      end else if (spd100) begin
         pol_cnt <= 2'h0;
         rev_pol <= 1'b0;
      end else begin
         if (nlp_ev) begin
            pol_cnt <= sync2.nlp_inv ? (pol_cnt == POL_COUNT ? pol_cnt : pol_cnt + 2'h1) : 2'h0;
         end
         if ((nlp_ev && sync2.nlp_inv && pol_cnt == POL_COUNT - 2'h1) ||
             (soi_ev && sync2.soi_inv)) begin
            rev_pol <= 1'b1;
         end else if (soi_ev) begin
            rev_pol <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx_invert <= 1'b0;
      end else begin
         rx_invert <= rev_pol & ~apol_dis;
      end
   end

   // ---------------------------------------------------------------
   // Register read
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= 16'h0000;
         unique case (reg_addr)
            REG_MAC_CTRL: begin
               reg_rdata[MAC_NEG_BIT] <= mac_side_negotiate_enable;
               reg_rdata[MAC_SPD_BIT] <= mac_spd;
               reg_rdata[MAC_DPX_BIT] <= mac_dpx;
            end
            REG_PHY_CTRL: begin
               reg_rdata[PHY_NEG_BIT] <= phy_side_negotiate_enable;
               reg_rdata[PHY_SPD_BIT] <= phy_spd;
               reg_rdata[PHY_DPX_BIT] <= duplex_select;
            end
            REG_CFG1: reg_rdata[CFG1_LDIS_BIT] <= link_dis;
            REG_CFG2: begin
               reg_rdata[CFG2_JDIS_BIT] <= jab_dis;
               reg_rdata[CFG2_PDIS_BIT] <= apol_dis;
            end
            REG_STATUS: begin
               reg_rdata[ST_DONE_BIT] <= negotiate_done_flag;
               reg_rdata[ST_JAB_BIT] <= jab_sts;
               reg_rdata[ST_LINK_BIT] <= link_pass;
            end
            REG_STS_OUT: begin
               reg_rdata[SO_SPD_BIT] <= neg_spd;
               reg_rdata[SO_DPX_BIT] <= neg_fdx;
               reg_rdata[SO_JAB_BIT] <= jab_so;
               reg_rdata[SO_POL_BIT] <= rev_pol;
            end
            REG_ADV: reg_rdata <= adv;
            REG_PARTNER: reg_rdata <= partner;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_neg_needs_both: assert property (!neg_on |=> state == ST_OFF)
      else $error("negotiation active without both enables");
   a_halt_min_time: assert property ($rose(state == ST_HALT) |-> (state == ST_HALT)[*8])
      else $error("halt period ended too early");
   a_halt_quiet: assert property (halted && $past(halted) |-> !tx_link_pulse && !tx_flp_send)
      else $error("pulse sent during halt");
   a_restart_halt: assert property (restart_req && neg_on |=> state == ST_HALT)
      else $error("restart did not start negotiation");
   a_done_on_link: assert property ($rose(negotiate_done_flag) |-> state == ST_LINK)
      else $error("done flag set outside link state");
   a_no_pulse_100: assert property (spd100 && $past(spd100) |-> !tx_link_pulse)
      else $error("link pulse sent at 100M");
   a_jab_off_100: assert property (spd100 |-> !jab_set ##1 !jabber)
      else $error("jabber active at 100M");
   a_jab_disabled: assert property (jab_dis |=> !jabber && !jab_set)
      else $error("jabber detected while disabled");
   a_jab_effects: assert property (jab_set |=> jabber ##1 tx_hold && (collision || fdx))
      else $error("jabber did not idle and collide");
   a_fdx_no_col: assert property (fdx |=> !collision)
      else $error("collision in full duplex");
   a_force_pass: assert property (link_dis |=> link_pass)
      else $error("link disable did not force pass");
   a_pol_disable: assert property (apol_dis |=> !rx_invert)
      else $error("inversion with autopolarity disabled");

endmodule

// ### verif/link_partner.sv
// Behavioural model of the remote twisted-pair link partner.
module link_partner
   import phy_link_pkg::*;
(
   input wire logic mclk,
   input wire logic [1:0] mode,
   input wire logic inv,
   input wire logic [15:0] adv,
   input wire logic tx_flp_send,
   input wire logic [15:0] tx_flp_word,
   input wire logic tx_hold,
   output line_in_t line_in,
   output logic [15:0] flp_rx_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic up = 1'h0;
   int n = 0;
   logic ack_now;
   assign ack_now = mode == 2'h3 && tx_flp_send && tx_flp_word[14];
   initial begin
      line_in = '0;
      flp_rx_word = '0;
   end
   // Mode 1 sends link pulses, mode 2 plain 100M idle, mode 3 answers bursts.
   always @(posedge mclk) begin
      n <= (n == 29) ? 0 : n + 1;
      line_in.nlp <= mode == 2'h1 && n == 0;
      line_in.nlp_inv <= inv;
      line_in.start_of_idle_pulse <= mode == 2'h1 && n == 15 && !inv;
      line_in.soi_inv <= inv;
      line_in.squelch_ok <= mode == 2'h2 || up || ack_now;
      line_in.descr_lock <= mode == 2'h2 || up || ack_now;
      line_in.rx_active <= mode == 2'h2;
      if (tx_hold) begin
         up <= 1'h0;
      end else if (ack_now) begin
         up <= 1'h1;
      end
      if (mode == 2'h3 && tx_flp_send) begin
         flp_rx_word <= adv | (tx_flp_word & 16'h4000);
         repeat (4) @(posedge mclk);
         line_in.flp_valid <= 1'h1;
         repeat (2) @(posedge mclk);
         line_in.flp_valid <= 1'h0;
         flp_rx_word <= ~flp_rx_word;
      end
   end
endmodule

// ### verif/phy_link_ctrl_tb.sv
// Self-checking bench for the PHY link management block.
module phy_link_ctrl_tb
   import phy_link_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, tx_en = 1'h0, inv = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, adv = 16'h01E1, reg_rdata, tx_flp_word, flp_rx_word;
   logic [1:0] mode = 2'h0;
   logic tx_link_pulse, tx_flp_send, tx_idle_100, tx_hold, link_pass;
   logic speed_100, full_duplex, collision, rx_invert;
   line_in_t line_in;
   int err_total = 0, tests_run = 0, cyc = 0, i;
   phy_link_ctrl #(.HALT_TIME(40), .LOSS_TIME(200), .GAP_TIME(20), .JAB_TIME(50))
      phy_link_ctrl_inst (.*);
   link_partner link_partner_inst (.*);
   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         conclude();
      end
   end
   // ----
   // Access and compare tasks
   // ----
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chb(input logic got, input logic exp);
      #1;
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata & m, e);
   endtask
   task automatic neg(input logic [3:0] a, input logic [15:0] d, input logic fdx);
      wr(a, d);
      for (i = 0; i < 4 && tx_hold !== 1'h1; i++) @(posedge mclk);
      chb(tx_hold, 1'h1);
      for (i = 0; i < 900 && !(tx_hold === 1'h0 && link_pass === 1'h1); i++) @(posedge mclk);
      chb(link_pass, 1'h1);
      chb(speed_100, 1'h1);
      chb(full_duplex, fdx);
      rd(REG_STATUS, 16'h0001, 16'h0001);
      rd(REG_STS_OUT, 16'h0003, {14'h0000, fdx, 1'h1});
   endtask
   task automatic conclude;
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (16) @(posedge mclk);
      nrst <= 1'h1;
      for (i = 0; i < 9; i++) begin
         rd(i[3:0], 16'hFFFF, i == 1 ? 16'h3000 : i == 6 ? 16'h01E1 : 16'h0000);
      end
      mode <= 2'h3;
      neg(REG_MAC_CTRL, 16'h0001, 1'h1);
      adv <= 16'h00A1;
      neg(REG_PHY_CTRL, 16'h1200, 1'h0);
      wr(REG_MAC_CTRL, 16'h0006);
      repeat (3) @(posedge mclk);
      chb(full_duplex, 1'h1);
      wr(REG_PHY_CTRL, 16'h0100);
      wr(REG_MAC_CTRL, 16'h0001);
      repeat (3) @(posedge mclk);
      chb(speed_100, 1'h0);
      chb(full_duplex, 1'h1);
      mode <= 2'h2;
      wr(REG_MAC_CTRL, 16'h0002);
      tx_en <= 1'h1;
      repeat (60) @(posedge mclk);
      chb(link_pass, 1'h1);
      chb(collision, 1'h1);
      chb(tx_hold, 1'h0);
      wr(REG_MAC_CTRL, 16'h0006);
      repeat (3) @(posedge mclk);
      chb(collision, 1'h0);
      mode <= 2'h0;
      wr(REG_MAC_CTRL, 16'h0000);
      repeat (60) @(posedge mclk);
      chb(tx_hold, 1'h1);
      chb(collision, 1'h1);
      tx_en <= 1'h0;
      rd(REG_STATUS, 16'h0002, 16'h0002);
      rd(REG_STS_OUT, 16'h0004, 16'h0004);
      wr(REG_CFG2, 16'h0001);
      tx_en <= 1'h1;
      repeat (60) @(posedge mclk);
      chb(tx_hold, 1'h0);
      tx_en <= 1'h0;
      mode <= 2'h1;
      inv <= 1'h1;
      wr(REG_CFG2, 16'h0000);
      repeat (150) @(posedge mclk);
      chb(link_pass, 1'h1);
      for (i = 0; i < 30 && tx_link_pulse !== 1'h1; i++) #100;
      chb(tx_link_pulse, 1'h1);
      chb(rx_invert, 1'h1);
      rd(REG_STS_OUT, 16'h0008, 16'h0008);
      wr(REG_CFG2, 16'h0002);
      repeat (3) @(posedge mclk);
      chb(rx_invert, 1'h0);
      inv <= 1'h0;
      repeat (60) @(posedge mclk);
      rd(REG_STS_OUT, 16'h0008, 16'h0000);
      mode <= 2'h0;
      inv <= 1'h0;
      wr(REG_CFG1, 16'h0001);
      wr(REG_PHY_CTRL, 16'h2100);
      repeat (3) @(posedge mclk);
      chb(link_pass, 1'h1);
      chb(speed_100, 1'h1);
      chb(tx_idle_100, 1'h1);
      conclude();
   end
endmodule
